// file: bench/dac_config_regs_tb.sv
// Self-checking bench for the control and configuration register block
module dac_config_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned BASE = 2;
	logic sys_clk;
	logic rst_n;
	logic clear_pin;
	logic sclk_pin;
	logic sdi_pin;
	logic latch_pin;
	logic sdo;
	logic slew_active;
	dac_regs_pkg::output_state_t out_state;
	logic [15:0] dac_code;
	logic [15:0] gain_trim_bits;
	logic signed [15:0] zero_trim_bits;
	int n_fail = 0;
	int cmp_count = 0;

	dac_config_regs #(.SLEW_BASE_CYCLES(BASE)) i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .sclk_pin(sclk_pin),
		.sdi_pin(sdi_pin), .latch_pin(latch_pin), .clear_pin(clear_pin),
		.sdo(sdo), .out_state(out_state), .dac_code(dac_code),
		.gain_trim_bits(gain_trim_bits), .zero_trim_bits(zero_trim_bits),
		.slew_active(slew_active)
	);

	spi_host_model i_host (
		.sys_clk(sys_clk), .sdo(sdo), .sclk_pin(sclk_pin),
		.sdi_pin(sdi_pin), .latch_pin(latch_pin)
	);

	// Free-running 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Compare one value and count the result
	task automatic chk(input string what, input logic [23:0] exp,
			input logic [23:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// One register write frame
	task automatic wr(input logic [7:0] addr, input logic [15:0] data);
		i_host.send_frame({addr, data});
	endtask

	// Output enables as {voltage_on, current_on}
	task automatic chk_on(input logic [1:0] exp);
		chk("outputs on", 24'(exp), 24'({out_state.voltage_on,
			out_state.current_on}));
	endtask

	// Pulse the clear pin and check the clear code
	task automatic clr(input logic [15:0] exp);
		clear_pin = 1'b1;
		i_host.tick(6);
		chk("clear code", 24'(exp), 24'(dac_code));
		clear_pin = 1'b0;
		i_host.tick(6);
	endtask

	// Print the counts and the verdict, then end the run
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Cuts a hang short after well over the expected run time
	initial begin
		#400000;
		n_fail++;
		wrap_up();
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		clear_pin = 1'b0;
		i_host.tick(5);
		rst_n = 1'b1;
		i_host.tick(3);
		chk("reset out_state", 24'h0, 24'(out_state));
		chk("reset code", 24'h0, 24'(dac_code));
		chk("reset sdo", 24'h0, 24'({sdo, slew_active}));
		// Outputs stay off while the enable bit is low
		wr(8'h55, 16'h6001);
		chk_on(2'b00);
		wr(8'h55, 16'h7001);
		chk_on(2'b10);
		chk("span", 24'h1, 24'(out_state.voltage_span));
		chk("overrange", 24'h1, 24'(out_state.overrange));
		chk("ext res", 24'h1, 24'(out_state.external_resistor));
		wr(8'h01, 16'h1234);
		chk("data code", 24'h1234, 24'(dac_code));
		chk("no slew", 24'h0, 24'(slew_active));
		// Dual output with separate current span and grounded sense node
		wr(8'h57, 16'h0580);
		chk_on(2'b11);
		chk("cur span", 24'h2, 24'(out_state.current_span));
		chk("v span", 24'h1, 24'(out_state.voltage_span));
		chk("sense gnd", 24'h1, 24'(out_state.sense_to_ground));
		chk("shared code", 24'h1234, 24'(dac_code));
		wr(8'h57, 16'h0080);
		chk_on(2'b10);
		chk("cur span", 24'h1, 24'(out_state.current_span));
		// Clear codes for each select value and polarity
		clr(16'h0000);
		wr(8'h55, 16'h9001);
		clr(16'h8000);
		wr(8'h55, 16'h9003);
		clr(16'h0000);
		wr(8'h55, 16'h1002);
		clr(16'h8000);
		// Trim registers and an unmapped address
		wr(8'h58, 16'hfedc);
		wr(8'h59, 16'h8001);
		wr(8'h33, 16'hffff);
		chk("gain", 24'hfedc, 24'(gain_trim_bits));
		chk("zero", 24'h8001, {8'h00, zero_trim_bits});
		// Control still 0x1002: voltage on, span 010, low bits as before
		chk("unmapped", 24'h00a002, 24'({out_state.voltage_on,
			out_state.voltage_span, 12'h002}));
		// Ramp by steps of four every two cycles
		wr(8'h01, 16'h0000);
		wr(8'h55, 16'h1052);
		wr(8'h01, 16'h0100);
		chk("ramping", 24'h1, 24'(slew_active));
		i_host.tick(200);
		chk("ramp end", 24'h0100, 24'(dac_code));
		chk("ramp idle", 24'h0, 24'(slew_active));
		// Slower clock field: eight steps of two, one every four cycles
		wr(8'h55, 16'h1132);
		wr(8'h01, 16'h0110);
		i_host.tick(20);
		chk("slow ramp", 24'h1, 24'(slew_active));
		i_host.tick(20);
		chk("slow end", 24'h0110, 24'(dac_code));
		// Chained output repeats the previous frame; slew fields ignored
		wr(8'h55, 16'h1fea);
		wr(8'h01, 16'h0200);
		wr(8'h58, 16'h1111);
		chk("chain out", 24'h010200, i_host.sdo_seen);
		chk("slew off", 24'h0200, 24'(dac_code));
		chk("gain", 24'h1111, 24'(gain_trim_bits));
		wrap_up();
	end
endmodule

// file: bench/spi_host_model.sv
// Serial host model that shifts write frames into the register block
module spi_host_model (
	input wire logic sys_clk,
	input wire logic sdo,
	output logic sclk_pin,
	output logic sdi_pin,
	output logic latch_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [23:0] sdo_seen;

	// Pins idle low until the first frame
	initial begin
		sclk_pin = 1'b0;
		sdi_pin = 1'b0;
		latch_pin = 1'b0;
		sdo_seen = 24'h000000;
	end

	// Wait n clock edges, then step off the edge by a fixed delay
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Exactly 24 clocks, most significant bit first, then the latch pulse
	task automatic send_frame(input logic [23:0] frame);
		for (int i = 23; i >= 0; i--) begin
			sdi_pin = frame[i];
			tick(5);
			sdo_seen = {sdo_seen[22:0], sdo}; // Chained bit seen before rise
			sclk_pin = 1'b1;
			tick(5);
			sclk_pin = 1'b0;
		end
		sdi_pin = ~frame[0]; // Released line does not keep its last value
		latch_pin = 1'b1;
		tick(5);
		latch_pin = 1'b0;
		tick(2);
	endtask
endmodule

// file: hw/dac_config_regs.sv
// Serial-written control, configuration and trim registers with output slew
module dac_config_regs #(
	parameter int unsigned SLEW_BASE_CYCLES = dac_regs_pkg::SLEW_BASE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sclk_pin,
	input wire logic sdi_pin,
	input wire logic latch_pin,
	input wire logic clear_pin,
	output logic sdo,
	output dac_regs_pkg::output_state_t out_state,
	output logic [15:0] dac_code,
	output logic [15:0] gain_trim_bits,
	output logic signed [15:0] zero_trim_bits,
	output logic slew_active
);

	// Clear value for the present range and clear select
	function automatic logic [15:0] clear_code(dac_regs_pkg::control_t c);
		logic bipolar;
		bipolar = !c.range_field[dac_regs_pkg::RANGE_CURRENT_BIT] &&
			c.range_field[dac_regs_pkg::RANGE_BIPOLAR_BIT];
		if (c.clear_value_select) begin
			clear_code = bipolar ? dac_regs_pkg::CODE_ZERO
				: dac_regs_pkg::CODE_MIDSCALE;
		end else begin
			clear_code = bipolar ? dac_regs_pkg::CODE_MIDSCALE
				: dac_regs_pkg::CODE_ZERO;
		end
	endfunction

	// Code increment per slew update
	function automatic logic [15:0] slew_increment(logic [2:0] step);
		slew_increment = 16'h0001 << step;
	endfunction

	// Pin order inside the synchroniser vectors
	localparam int P_SCLK = 0;
	localparam int P_SDI = 1;
	localparam int P_LATCH = 2;
	localparam int P_CLEAR = 3;

	logic [3:0] pins_meta_ff;
	logic [3:0] pins_sync_ff;
	logic [3:0] pins_prev_ff;
	logic [23:0] shift_ff;
	logic sdo_ff;
	dac_regs_pkg::control_t control_ff;
	dac_regs_pkg::config_t config_ff;
	logic [15:0] data_ff;
	logic [15:0] gain_ff;
	logic [15:0] zero_ff;
	logic [15:0] code_ff;
	logic [31:0] tick_cnt_ff;
	dac_regs_pkg::output_state_t out_ff;

	// Two-stage synchronisers, then a history stage for edge detection
	always_ff @(posedge sys_clk) begin
		pins_meta_ff <= {clear_pin, latch_pin, sdi_pin, sclk_pin};
		pins_sync_ff <= pins_meta_ff;
		pins_prev_ff <= pins_sync_ff;
	end

	// Edges and levels of the synchronised pins
	wire sclk_rise = pins_sync_ff[P_SCLK] && !pins_prev_ff[P_SCLK];
	wire sclk_fall = !pins_sync_ff[P_SCLK] && pins_prev_ff[P_SCLK];
	wire latch_rise = pins_sync_ff[P_LATCH] && !pins_prev_ff[P_LATCH];
	wire clear_level = pins_sync_ff[P_CLEAR];

	// Frame fields as they stand in the shift register
	wire [7:0] frame_addr = shift_ff[dac_regs_pkg::ADDR_MSB:
		dac_regs_pkg::ADDR_LSB];
	wire [15:0] frame_data = shift_ff[15:0];
	wire dac_regs_pkg::control_t frame_control = frame_data;

	// Write strobes, all taken on the latch rising edge
	wire we_control = latch_rise &&
		frame_addr == dac_regs_pkg::ADDR_CONTROL;
	wire we_config = latch_rise &&
		frame_addr == dac_regs_pkg::ADDR_CONFIG;
	wire we_data = latch_rise && frame_addr == dac_regs_pkg::ADDR_DATA;
	wire we_gain = latch_rise && frame_addr == dac_regs_pkg::ADDR_GAIN;
	wire we_zero = latch_rise && frame_addr == dac_regs_pkg::ADDR_ZERO;
	wire range_change = we_control &&
		frame_control.range_field != control_ff.range_field;

	// Serial shift in on sclk rise; chained output on sclk fall
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			shift_ff <= 24'h000000;
			sdo_ff <= 1'b0;
		end else begin
			if (sclk_rise) begin
				shift_ff <= {shift_ff[22:0], pins_sync_ff[P_SDI]};
			end
			if (sclk_fall) begin
				sdo_ff <= control_ff.chain_enable && shift_ff[23];
			end
		end
	end

	// Next register values
	wire [15:0] nxt_control = we_control ? frame_data : control_ff;
	wire [15:0] nxt_config = we_config ? shift_ff[15:0] : config_ff;
	wire [15:0] nxt_gain = we_gain ? frame_data : gain_ff;
	wire [15:0] nxt_zero = we_zero ? frame_data : zero_ff;
	wire [15:0] nxt_data = we_data ? frame_data
		: range_change ? dac_regs_pkg::DATA_RESET : data_ff;

	// Register storage with documented reset defaults
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			control_ff <= dac_regs_pkg::CONTROL_RESET;
			config_ff <= dac_regs_pkg::CONFIG_RESET;
			gain_ff <= dac_regs_pkg::GAIN_RESET;
			zero_ff <= dac_regs_pkg::ZERO_RESET;
			data_ff <= dac_regs_pkg::DATA_RESET;
		end else begin
			control_ff <= nxt_control;
			config_ff <= nxt_config;
			gain_ff <= nxt_gain;
			zero_ff <= nxt_zero;
			data_ff <= nxt_data;
		end
	end

	// Output steering decode
	wire dual = config_ff.both_outputs_enable;
	wire is_current = control_ff.range_field[dac_regs_pkg::RANGE_CURRENT_BIT];
	wire en = control_ff.output_enable_bit;
	dac_regs_pkg::output_state_t nxt_out;
	assign nxt_out.voltage_on = en && (dual || !is_current);
	assign nxt_out.current_on = en && (dual || is_current);
	assign nxt_out.voltage_span = control_ff.range_field;
	assign nxt_out.current_span = dual ? config_ff.current_span_select
		: control_ff.range_field[1:0];
	assign nxt_out.overrange = control_ff.overrange_enable;
	assign nxt_out.external_resistor =
		control_ff.external_resistor_enable;
	assign nxt_out.sense_to_ground = config_ff.alternate_powerdown;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			out_ff <= '0;
		end else begin
			out_ff <= nxt_out;
		end
	end

	// Target code: clear value while clear is held, else the data register
	wire [15:0] clear_value = clear_code(control_ff);
	wire [15:0] target = clear_level ? clear_value : data_ff;
	wire slewing = control_ff.slew_enable && !clear_level &&
		code_ff != target;
	wire [31:0] slew_period = SLEW_BASE_CYCLES <<
		control_ff.slew_clock_field;
	wire slew_tick = slewing && tick_cnt_ff >= slew_period - 32'd1;
	wire [15:0] step = slew_increment(control_ff.slew_step_field);
	wire [15:0] gap_up = target - code_ff;
	wire [15:0] gap_down = code_ff - target;
	wire [15:0] slew_next = (code_ff < target)
		? ((gap_up <= step) ? target : code_ff + step)
		: ((gap_down <= step) ? target : code_ff - step);
	wire [15:0] nxt_code = slewing ? (slew_tick ? slew_next : code_ff)
		: target;

	// Slew divider, held at zero while not slewing
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !slewing || slew_tick) begin
			tick_cnt_ff <= 32'd0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'd1;
		end
	end

	// Shared output code, starting at the reset clear value
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			code_ff <= dac_regs_pkg::CODE_ZERO;
		end else begin
			code_ff <= nxt_code;
		end
	end

	assign sdo = sdo_ff;
	assign out_state = out_ff;
	assign dac_code = code_ff;
	assign gain_trim_bits = gain_ff;
	assign zero_trim_bits = zero_ff;
	assign slew_active = slewing;

	// Checks on the block's own behaviour
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	chk_control_write: assert property (
		we_control |=> control_ff == $past(frame_data))
		else $error("control register missed a frame");
	chk_config_write: assert property (
		we_config |=> config_ff == $past(frame_data))
		else $error("configuration register missed a frame");
	chk_no_latch_hold: assert property (
		!latch_rise |=> $stable(control_ff) && $stable(config_ff))
		else $error("register changed without latch edge");
	chk_clear_zero: assert property (
		clear_level && !we_control && !control_ff.clear_value_select &&
		!control_ff.range_field[1] |=> code_ff == dac_regs_pkg::CODE_ZERO)
		else $error("clear value wrong with select low");
	chk_clear_alt: assert property (
		clear_level && !we_control && control_ff.clear_value_select &&
		control_ff.range_field == 3'h0 |=>
		code_ff == dac_regs_pkg::CODE_MIDSCALE)
		else $error("clear value wrong with select high");
	chk_out_disable: assert property (
		!control_ff.output_enable_bit |=>
		!out_state.voltage_on && !out_state.current_on)
		else $error("output on while disabled");
	chk_dual_spans: assert property (
		en && dual |=> out_state.voltage_on && out_state.current_on &&
		out_state.voltage_span == $past(control_ff.range_field) &&
		out_state.current_span == $past(config_ff.current_span_select))
		else $error("dual output steering wrong");
	chk_single_span: assert property (
		!dual && is_current |=>
		out_state.current_span == $past(control_ff.range_field[1:0]))
		else $error("current span ignored range bits");
	chk_direct_jump: assert property (
		!control_ff.slew_enable |=> code_ff == $past(target))
		else $error("code did not jump with slew off");
	chk_slew_step: assert property (
		slew_tick && code_ff < target |=>
		code_ff > $past(code_ff) &&
		code_ff - $past(code_ff) <= $past(step))
		else $error("slew step out of bounds");
	chk_slew_wait: assert property (
		slewing && !slew_tick && !clear_level |=> $stable(code_ff))
		else $error("code moved between slew updates");
	chk_range_reset: assert property (
		range_change && !we_data |=> data_ff == dac_regs_pkg::DATA_RESET)
		else $error("range change kept data");
	chk_span_keeps: assert property (
		we_config |=> data_ff == $past(data_ff))
		else $error("configuration write changed data");
	chk_chain_out: assert property (
		sclk_fall && control_ff.chain_enable |=> sdo == $past(shift_ff[23]))
		else $error("chained output bit wrong");

	// Trim registers take their frames unchanged
	chk_gain_write: assert property (
		we_gain |=> gain_ff == $past(frame_data))
		else $error("gain trim register missed a frame");
	chk_zero_write: assert property (
		we_zero |=> zero_ff == $past(frame_data))
		else $error("zero trim register missed a frame");

	// Output stage steering follows the stored control and configuration bits
	chk_dual_vspan: assert property (
		dual |=> out_state.voltage_span == $past(control_ff.range_field))
		else $error("voltage span left the range bits in dual mode");
	chk_sense_node: assert property (
		config_ff.alternate_powerdown |=> out_state.sense_to_ground)
		else $error("sense node not grounded");
	chk_overrange: assert property (
		control_ff.overrange_enable |=> out_state.overrange)
		else $error("overrange not passed to output stage");
	chk_ext_resistor: assert property (
		control_ff.external_resistor_enable |=> out_state.external_resistor)
		else $error("external resistor not selected");

	// Slew only runs when enabled, and steps down by at most one step
	chk_slew_flag: assert property (
		!control_ff.slew_enable |-> !slew_active)
		else $error("slewing while slew control is off");
	chk_slew_down: assert property (
		slew_tick && code_ff > target |=>
		code_ff < $past(code_ff) &&
		$past(code_ff) - code_ff <= $past(step))
		else $error("downward slew step out of bounds");

	// Main scenarios worth seeing
	cov_slew_ramp: cover property (slew_tick ##1 slew_tick);
	cov_slow_slew: cover property (
		slew_tick && control_ff.slew_clock_field != 4'h0);
	cov_clear_mode: cover property ($rose(clear_level));
	cov_dual_out: cover property (out_state.voltage_on && out_state.current_on);
	cov_chain_frame: cover property (control_ff.chain_enable && latch_rise);

endmodule

// file: hw/dac_regs_pkg.sv
// Register layout, frame layout and timing constants of the output converter
package dac_regs_pkg;

	// Frame layout: one address byte followed by one data word
	localparam int FRAME_BITS = 24;
	localparam int DATA_WIDTH = 16;
	localparam int ADDR_MSB = 23;
	localparam int ADDR_LSB = 16;

	// Address bytes of the write frames
	localparam logic [7:0] ADDR_DATA = 8'h01;
	localparam logic [7:0] ADDR_CONTROL = 8'h55;
	localparam logic [7:0] ADDR_CONFIG = 8'h57;
	localparam logic [7:0] ADDR_GAIN = 8'h58;
	localparam logic [7:0] ADDR_ZERO = 8'h59;

	// Reset values
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] CONFIG_RESET = 16'h0000;
	localparam logic [15:0] GAIN_RESET = 16'h0000;
	localparam logic [15:0] ZERO_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	// Codes used as clear values
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MIDSCALE = 16'h8000;

	// Bit positions inside the range field
	localparam int RANGE_BIPOLAR_BIT = 1;
	localparam int RANGE_CURRENT_BIT = 2;

	// Slew update base period, scaled by a power of two per clock field step
	localparam int SYS_CLK_NS = 10;
	localparam int SLEW_BASE_NS = 1000;
	localparam int SLEW_BASE_CYCLES =
		(SLEW_BASE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

	// Control word, most significant field first
	typedef struct packed {
		logic clear_value_select;
		logic overrange_enable;
		logic external_resistor_enable;
		logic output_enable_bit;
		logic [3:0] slew_clock_field;
		logic [2:0] slew_step_field;
		logic slew_enable;
		logic chain_enable;
		logic [2:0] range_field;
	} control_t;

	// Configuration word, most significant field first
	typedef struct packed {
		logic [4:0] reserved_high;
		logic [1:0] current_span_select;
		logic both_outputs_enable;
		logic alternate_powerdown;
		logic reserved_low;
		logic [5:0] other_bits;
	} config_t;

	// Analog front-end steering presented to the output stage
	typedef struct packed {
		logic voltage_on;
		logic current_on;
		logic [2:0] voltage_span;
		logic [1:0] current_span;
		logic overrange;
		logic external_resistor;
		logic sense_to_ground;
	} output_state_t;

endpackage
